// *** common/adc_seq_pkg.sv ***
// adc_seq_pkg: constants and types for the conversion sequencer
// assumes: one 50 MHz bus clock, conversion clock given as an enable pulse
package adc_seq_pkg;

	// ------------------------------------------------------------
	// field layouts
	// ------------------------------------------------------------
	localparam int CHAN_W = 5;
	localparam logic [4:0] CHAN_OFF = 5'h1F;
	localparam int RES_W = 10;
	localparam logic [1:0] CLKSEL_ASYNC = 2'h3;
	localparam logic [1:0] MODE_8BIT = 2'h0;
	localparam logic [1:0] MODE_10BIT = 2'h2;

	// ------------------------------------------------------------
	// timing: conversion-clock and bus-clock counts per phase
	// ------------------------------------------------------------
	localparam logic [5:0] SAMPLE_SHORT_CYC = 6'h03;
	localparam logic [5:0] SAMPLE_LONG_CYC = 6'h17;
	localparam logic [5:0] APPROX_8_CYC = 6'h0E;
	localparam logic [5:0] APPROX_10_CYC = 6'h11;
	localparam logic [5:0] FIRST_EXTRA_CYC = 6'h03;
	localparam logic [3:0] BUS_EXTRA_CYC = 4'h5;
	localparam int CLK_SYS_MHZ = 50;
	localparam int ASYNC_START_US = 5;
	localparam int ASYNC_START_CYC = ASYNC_START_US * CLK_SYS_MHZ;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_SETUP = 3'b010,
		ST_SAMPLE = 3'b011,
		ST_APPROX = 3'b100,
		ST_FINISH = 3'b101
	} seq_state_t;

	localparam logic [RES_W-1:0] RESULT_RST = 10'h000;

endpackage : adc_seq_pkg

// *** core/adc_conversion_sequencer.sv ***
// adc_conversion_sequencer: start, abort, blocking and compare control of a
// successive-approximation converter; analog core reached over plain ports
// assumes: conversion clock arrives as a one-cycle enable on clk_sys_i,
// register writes and reads arrive as one-cycle strobes from the bus logic
`timescale 1ns/10ps
`default_nettype none

// Operation
// - software mode: control-one write starts conversion unless channel all ones
// - hardware mode: trigger input event starts conversion, writes do not
// - continuous: restart after each transfer until abort; hw waits first edge
// - completion writes result registers, sets flag, interrupt if enabled
// - 10-bit high read pending low read blocks transfer; flag stays clear
// - blocked single compare-false conversion just terminates
// - other blocked transfers restart conversion regardless of continuous bit
// - control-one write aborts; restarts in software mode unless channel all ones
// - writes to control-two, config or compare values abort conversion
// - reset aborts; stop aborts unless async clock selected
// - abort keeps last results; reset clears them
// - idle until started; async clock enabled only while converting with it
// - sample short or long, then isolate and approximate, then transfer
// - first conversion at most 20/23 or 40/43 clocks plus 5 bus cycles
// - async clock adds 5 us start-up to first conversion
// - later continuous: 17/20 or 37/40 clocks, no bus cycles
// - continuous sample timing holds only with adequate bus clock rate
// - compare adds negated compare value; flag on ge or lt condition
// - compare true stores difference, not raw result
// - compare false: no flag, no transfer
// - wait mode: conversion finishes, triggers still start, completion wakes
// - disabled during reset or channel select all ones
// - trigger starts on rising edge; ignored while busy; continuous first only
// - result rounded to 10 bits, or 8 bits in low register
module adc_conversion_sequencer #(
	parameter int ASYNC_START_CYCLES = adc_seq_pkg::ASYNC_START_CYC
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic conv_clk_en_i,
	input wire logic ctrl_one_wr_i,
	input wire logic [4:0] channel_select_i,
	input wire logic continuous_enable_i,
	input wire logic complete_irq_enable_i,
	input wire logic ctrl_two_wr_i,
	input wire logic hw_trigger_select_i,
	input wire logic compare_enable_i,
	input wire logic compare_greater_select_i,
	input wire logic config_wr_i,
	input wire logic [1:0] mode_select_i,
	input wire logic long_sample_select_i,
	input wire logic [1:0] input_clock_select_i,
	input wire logic compare_wr_i,
	input wire logic [9:0] compare_value_i,
	input wire logic result_high_rd_i,
	input wire logic result_low_rd_i,
	input wire logic stop_mode_i,
	input wire logic hw_trigger_input_i,
	input wire logic [10:0] approx_value_i,
	output logic [9:0] result_o,
	output logic conv_complete_flag_o,
	output logic irq_o,
	output logic active_o,
	output logic sample_o,
	output logic async_clk_en_o
);

	// ------------------------------------------------------------
	// trigger pin synchroniser and edge detect
	// ------------------------------------------------------------
	logic trig_meta_q, trig_sync_q, trig_prev_q;
	logic trig_meta_d, trig_sync_d, trig_prev_d;
	logic trig_rise;

	always_comb begin
		trig_meta_d = hw_trigger_input_i;
		trig_sync_d = trig_meta_q;
		trig_prev_d = trig_sync_q;
		trig_rise = trig_sync_q & ~trig_prev_q;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			trig_meta_q <= 1'b0;
			trig_sync_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end else begin
			trig_meta_q <= trig_meta_d;
			trig_sync_q <= trig_sync_d;
			trig_prev_q <= trig_prev_d;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	adc_seq_pkg::seq_state_t state_q, state_d;
	logic [8:0] cnt_q, cnt_d;
	logic first_q, first_d;
	logic cont_run_q, cont_run_d;
	logic block_q, block_d;
	logic [9:0] result_q, result_d;
	logic flag_q, flag_d;
	logic irq_q, irq_d;
	logic active_q, active_d;
	logic sample_q, sample_d;
	logic aclk_q, aclk_d;

	logic chan_off;
	logic ten_bit;
	logic abort;
	logic start;
	logic [10:0] rounded;
	logic [9:0] raw;
	logic [10:0] diff;
	logic cmp_true;
	logic [5:0] sample_len;
	logic [5:0] approx_len;

	always_comb begin
		chan_off = (channel_select_i == adc_seq_pkg::CHAN_OFF);
		ten_bit = (mode_select_i == adc_seq_pkg::MODE_10BIT);
		// rounding: add half lsb of target width
		rounded = ten_bit ? (approx_value_i + 11'h001) : (approx_value_i + 11'h004);
		raw = ten_bit ? rounded[10:1] : {2'h0, rounded[10:3]};
		if (ten_bit && rounded[10:1] == 10'h000 && approx_value_i[10]) begin
			raw = 10'h3FF;
		end
		if (!ten_bit && rounded[10:3] == 8'h00 && approx_value_i[10]) begin
			raw = 10'h0FF;
		end
		diff = {1'b0, raw} + {1'b1, ~compare_value_i} + 11'h001;
		// diff[10] set means a borrow: result below the compare value
		cmp_true = compare_greater_select_i ? ~diff[10] : diff[10];
		sample_len = long_sample_select_i ? adc_seq_pkg::SAMPLE_LONG_CYC
			: adc_seq_pkg::SAMPLE_SHORT_CYC;
		approx_len = ten_bit ? adc_seq_pkg::APPROX_10_CYC
			: adc_seq_pkg::APPROX_8_CYC;
		// stop aborts unless async clock runs the conversion
		abort = ctrl_one_wr_i | ctrl_two_wr_i | config_wr_i | compare_wr_i
			| (stop_mode_i && input_clock_select_i != adc_seq_pkg::CLKSEL_ASYNC);
		start = 1'b0;
		if (!chan_off && !abort) begin
			if (hw_trigger_select_i) begin
				start = trig_rise;
			end
		end
		if (ctrl_one_wr_i && !hw_trigger_select_i && !chan_off) begin
			start = 1'b1;
		end
	end

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		first_d = first_q;
		cont_run_d = cont_run_q;
		block_d = block_q;
		result_d = result_q;
		flag_d = flag_q;
		irq_d = 1'b0;
		// reading either result byte clears the flag
		if (result_low_rd_i || result_high_rd_i || ctrl_one_wr_i) begin
			flag_d = 1'b0;
		end
		if (result_high_rd_i && ten_bit) begin
			block_d = 1'b1;
		end
		if (result_low_rd_i) begin
			block_d = 1'b0;
		end
		case (state_q)
			adc_seq_pkg::ST_IDLE: begin
				if (start) begin
					state_d = adc_seq_pkg::ST_START;
					first_d = 1'b1;
					cont_run_d = continuous_enable_i;
					cnt_d = 9'h000;
				end
			end
			adc_seq_pkg::ST_START: begin
				// bus cycles, or async start-up instead of them, on a first conversion
				cnt_d = cnt_q + 9'h001;
				if ((input_clock_select_i != adc_seq_pkg::CLKSEL_ASYNC
					&& cnt_q >= 9'(adc_seq_pkg::BUS_EXTRA_CYC) - 9'h001)
					|| cnt_q >= 9'(ASYNC_START_CYCLES) - 9'h001) begin
					state_d = adc_seq_pkg::ST_SETUP;
					cnt_d = 9'h000;
				end
			end
			adc_seq_pkg::ST_SETUP: begin
				if (conv_clk_en_i) begin
					cnt_d = cnt_q + 9'h001;
					if (cnt_q >= 9'(adc_seq_pkg::FIRST_EXTRA_CYC) - 9'h001) begin
						state_d = adc_seq_pkg::ST_SAMPLE;
						cnt_d = 9'h000;
					end
				end
			end
			adc_seq_pkg::ST_SAMPLE: begin
				if (conv_clk_en_i) begin
					cnt_d = cnt_q + 9'h001;
					if (cnt_q >= {3'h0, sample_len} - 9'h001) begin
						state_d = adc_seq_pkg::ST_APPROX;
						cnt_d = 9'h000;
					end
				end
			end
			adc_seq_pkg::ST_APPROX: begin
				if (conv_clk_en_i) begin
					cnt_d = cnt_q + 9'h001;
					if (cnt_q >= {3'h0, approx_len} - 9'h001) begin
						state_d = adc_seq_pkg::ST_FINISH;
					end
				end
			end
			adc_seq_pkg::ST_FINISH: begin
				cnt_d = 9'h000;
				first_d = 1'b0;
				state_d = adc_seq_pkg::ST_IDLE;
				if (compare_enable_i && !cmp_true) begin
					// nothing transferred; a blocked single just ends
					if (cont_run_q || (block_q && !compare_enable_i)) begin
						state_d = adc_seq_pkg::ST_SAMPLE;
					end
				end else if (block_q) begin
					state_d = adc_seq_pkg::ST_SAMPLE;
				end else begin
					result_d = compare_enable_i ? diff[9:0] : raw;
					flag_d = 1'b1;
					irq_d = complete_irq_enable_i;
					if (cont_run_q) begin
						state_d = adc_seq_pkg::ST_SAMPLE;
					end
				end
			end
			default: begin
				state_d = adc_seq_pkg::ST_IDLE;
			end
		endcase
		if (abort) begin
			state_d = adc_seq_pkg::ST_IDLE;
			cnt_d = 9'h000;
			// an aborted finish transfers nothing
			result_d = result_q;
			flag_d = flag_q && !(result_low_rd_i || result_high_rd_i || ctrl_one_wr_i);
			irq_d = 1'b0;
			if (start) begin
				state_d = adc_seq_pkg::ST_START;
				first_d = 1'b1;
				cont_run_d = continuous_enable_i;
			end
		end else if (start && state_q != adc_seq_pkg::ST_IDLE
			&& !hw_trigger_select_i) begin
			state_d = adc_seq_pkg::ST_START;
		end
		active_d = (state_d != adc_seq_pkg::ST_IDLE);
		sample_d = (state_d == adc_seq_pkg::ST_SAMPLE);
		aclk_d = active_d && input_clock_select_i == adc_seq_pkg::CLKSEL_ASYNC;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= adc_seq_pkg::ST_IDLE;
			cnt_q <= 9'h000;
			first_q <= 1'b0;
			cont_run_q <= 1'b0;
			block_q <= 1'b0;
			result_q <= adc_seq_pkg::RESULT_RST;
			flag_q <= 1'b0;
			irq_q <= 1'b0;
			active_q <= 1'b0;
			sample_q <= 1'b0;
			aclk_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			first_q <= first_d;
			cont_run_q <= cont_run_d;
			block_q <= block_d;
			result_q <= result_d;
			flag_q <= flag_d;
			irq_q <= irq_d | (irq_q & flag_d & complete_irq_enable_i);
			active_q <= active_d;
			sample_q <= sample_d;
			aclk_q <= aclk_d;
		end
	end

	assign result_o = result_q;
	assign conv_complete_flag_o = flag_q;
	assign irq_o = irq_q;
	assign active_o = active_q;
	assign sample_o = sample_q;
	assign async_clk_en_o = aclk_q;

endmodule : adc_conversion_sequencer

`default_nettype wire

// *** testbench/adc_seq_properties.sv ***
// adc_seq_properties: port properties of the conversion sequencer
// assumes: bound to adc_conversion_sequencer, levels held steady around strobes
`timescale 1ns/10ps
`default_nettype none
module adc_seq_properties (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ctrl_one_wr_i,
	input wire logic [4:0] channel_select_i,
	input wire logic complete_irq_enable_i,
	input wire logic ctrl_two_wr_i,
	input wire logic hw_trigger_select_i,
	input wire logic config_wr_i,
	input wire logic [1:0] input_clock_select_i,
	input wire logic compare_wr_i,
	input wire logic stop_mode_i,
	input wire logic [9:0] result_o,
	input wire logic conv_complete_flag_o,
	input wire logic irq_o,
	input wire logic active_o,
	input wire logic async_clk_en_o
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	wire logic mode_wr = ctrl_two_wr_i || config_wr_i || compare_wr_i;
	sw_start_a: assert property (ctrl_one_wr_i && channel_select_i != 5'h1F &&
		!hw_trigger_select_i && !stop_mode_i |=> active_o) else $error("no start");
	chan_off_a: assert property (ctrl_one_wr_i && channel_select_i == 5'h1F
		|=> !active_o) else $error("started with channel off");
	hw_no_sw_a: assert property (ctrl_one_wr_i && hw_trigger_select_i && !active_o
		|=> !active_o [*2]) else $error("write started hw mode");
	mode_abort_a: assert property (mode_wr |=> !active_o) else $error("no abort");
	keep_result_a: assert property (mode_wr |=> $stable(result_o)) else $error("abort result");
	stop_abort_a: assert property (stop_mode_i && input_clock_select_i != 2'h3
		|=> !active_o) else $error("stop did not abort");
	irq_set_a: assert property ($rose(conv_complete_flag_o)
		|-> irq_o == complete_irq_enable_i) else $error("irq wrong");
	async_gate_a: assert property (async_clk_en_o
		|-> active_o && input_clock_select_i == 2'h3) else $error("async clock on");
	reset_clear_a: assert property ($fell(rst_i)
		|-> result_o == 10'h000 && !conv_complete_flag_o && !active_o) else $error("reset");
endmodule : adc_seq_properties
bind adc_conversion_sequencer adc_seq_properties u_props (.*);
`default_nettype wire

// *** testbench/tb_top.sv ***
// tb_top: self-checking bench for the conversion sequencer
// assumes: conversion clock enable tied high, so one conversion clock per bus clock
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_sys_i = 0;
	logic rst_i = 1;
	logic [5:0] st = 0;
	wire ctrl_one_wr_i = st[0];
	wire ctrl_two_wr_i = st[1];
	wire config_wr_i = st[2];
	wire compare_wr_i = st[3];
	wire result_high_rd_i = st[4];
	wire result_low_rd_i = st[5];
	logic [4:0] channel_select_i = 5'h01;
	logic continuous_enable_i = 0, complete_irq_enable_i = 0, hw_trigger_select_i = 0;
	logic compare_enable_i = 0, compare_greater_select_i = 0, long_sample_select_i = 0;
	logic stop_mode_i = 0, hw_trigger_input_i = 0, conv_clk_en_i = 1;
	logic [1:0] mode_select_i = 0, input_clock_select_i = 0;
	logic [9:0] compare_value_i = 0, result_o, last = 0;
	logic [10:0] approx_value_i = 0;
	logic conv_complete_flag_o, irq_o, active_o, sample_o, async_clk_en_o;
	int fail_count = 0, compares = 0, n;
	// rows: greater select, result, compare value, flag expected
	logic [21:0] rows [4] = '{{1'b1, 10'h100, 10'h100, 1'b1}, {1'b1, 10'h0FF, 10'h100, 1'b0},
		{1'b0, 10'h0FF, 10'h100, 1'b1}, {1'b0, 10'h100, 10'h100, 1'b0}};
	adc_conversion_sequencer #(.ASYNC_START_CYCLES(8)) u_dut (.*);
	initial forever #10 clk_sys_i = ~clk_sys_i;
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [10:0] s, input logic [10:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch t=%0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("fail_count=%0d compares=%0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	task automatic wr(input int k);
		@(negedge clk_sys_i);
		st = 6'h01 << k;
		@(negedge clk_sys_i);
		st = 0;
	endtask : wr
	task automatic wf(output int c);
		c = 0;
		while (conv_complete_flag_o !== 1'b1) begin
			@(negedge clk_sys_i);
			c++;
			if (c > 300) begin
				chk(0, 1);
				report_and_stop;
			end
		end
	endtask : wf
	initial begin
		repeat (20) @(negedge clk_sys_i);
		rst_i = 0;
		chk({result_o, active_o}, 0);
		for (int i = 0; i < 4; i++) begin
			{mode_select_i, long_sample_select_i} = {i[0], 1'b0, i[1]};
			wr(2);
			wr(0);
			repeat (8) @(negedge clk_sys_i);
			chk(sample_o, 1);
			wf(n);
			chk(n <= (i[1] ? 40 : 20) + (i[0] ? 3 : 0) + 9, 1);
			chk(irq_o, 0);
			wr(5);
		end
		{compare_enable_i, complete_irq_enable_i} = 2'b11;
		foreach (rows[i]) begin
			compare_greater_select_i = rows[i][21];
			wr(1);
			compare_value_i = rows[i][10:1];
			wr(3);
			approx_value_i = {rows[i][20:11], 1'b0};
			wr(0);
			if (rows[i][0]) begin
				wf(n);
				last = rows[i][20:11] - rows[i][10:1];
				chk(irq_o, 1);
				wr(5);
			end else repeat (70) @(negedge clk_sys_i);
			chk({result_o, conv_complete_flag_o}, {last, 1'b0});
			chk(active_o, 0);
		end
		compare_enable_i = 0;
		wr(1);
		approx_value_i = 11'h2AA;
		wr(0);
		wf(n);
		wr(4);
		approx_value_i = 11'h154;
		wr(0);
		repeat (70) @(negedge clk_sys_i);
		chk({result_o, conv_complete_flag_o, active_o}, {10'h155, 2'b01});
		wr(5);
		wf(n);
		chk(result_o, 10'h0AA);
		wr(5);
		{mode_select_i, long_sample_select_i, continuous_enable_i} = 4'b0001;
		wr(2);
		wr(0);
		wf(n);
		wr(5);
		wf(n);
		chk(n <= 19, 1);
		wr(5);
		wr(1);
		chk(active_o, 0);
		continuous_enable_i = 0;
		hw_trigger_select_i = 1;
		wr(1);
		wr(0);
		repeat (3) @(negedge clk_sys_i);
		chk(active_o, 0);
		hw_trigger_input_i = 1;
		wf(n);
		hw_trigger_input_i = 0;
		chk(n < 40, 1);
		hw_trigger_select_i = 0;
		wr(1);
		wr(0);
		stop_mode_i = 1;
		@(negedge clk_sys_i);
		stop_mode_i = 0;
		chk(active_o, 0);
		input_clock_select_i = 2'h3;
		wr(2);
		wr(0);
		stop_mode_i = 1;
		@(negedge clk_sys_i);
		chk({active_o, async_clk_en_o}, 2'b11);
		wf(n);
		stop_mode_i = 0;
		chk(n <= 38 + 8, 1);
		channel_select_i = 5'h1F;
		wr(0);
		chk(active_o, 0);
		channel_select_i = 5'h01;
		wr(0);
		rst_i = 1;
		@(negedge clk_sys_i);
		rst_i = 0;
		chk({result_o, conv_complete_flag_o}, 0);
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
